// ---- logic/loop_filter_coefficient_decode.sv ----
// Loop filter coefficient decoder with an AHB-Lite register slave.
// What this block does
// - First coefficient is mantissa times two to minus16 minus shift plus gains
// - First coefficient shift field accepts 0 to 63, moving point leftward
// - First coefficient mantissa is unsigned, usable 1 to 65535
// - Front-end gain field holds at most 7; more goes to back-end
// - Combined gain reaches at most 22; back-end field accepts up to 15
// - Second coefficient magnitude is mantissa times two to minus(17+exp)
// - Second coefficient exponent accepts 0 to 31
// - Second coefficient mantissa is unsigned, usable 1 to 131071
// - Third coefficient magnitude is mantissa times two to minus(17+exp)
// - Third coefficient exponent accepts 0 to 31
// - Third coefficient mantissa is unsigned, usable 1 to 131071
// - Fourth coefficient is positive mantissa times two to minus(15+exp)
// - Fourth coefficient exponent accepts 0 to 31
// - Fourth coefficient mantissa is unsigned, usable 1 to 32767
// - Second and third are stored positive and negated inside the core
`timescale 1ns/10ps

module loop_filter_coefficient_decode #(
  parameter int coef_w = 72,
  parameter int frac_w = 48
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Decoded scale factors, signed fixed point with frac_w fraction bits
  output logic signed [coef_w-1:0] alpha_coef,
  output logic signed [coef_w-1:0] beta_coef,
  output logic signed [coef_w-1:0] gamma_coef,
  output logic signed [coef_w-1:0] delta_coef
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Alpha can grow to 65535 * 2^6, so 22 integer bits plus sign are needed
  if (frac_w < coef_decode_pkg::alpha_base || coef_w < frac_w + 24) begin
    $error("coef_w or frac_w too small for the coefficient range");
  end

  // ----------------------------------------------------------------
  // Field registers
  // ----------------------------------------------------------------
  logic [15:0] alpha_mant_reg;
  logic [5:0] alpha_shift_reg;
  logic [2:0] alpha_front_reg;
  logic [3:0] alpha_back_reg;
  logic [16:0] beta_mant_reg;
  logic [4:0] beta_exp_reg;
  logic [16:0] gamma_mant_reg;
  logic [4:0] gamma_exp_reg;
  logic [14:0] delta_mant_reg;
  logic [4:0] delta_exp_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;

  // Address phase decode
  wire addr_take = hsel & htrans[1] & hready;
  wire wr_now = wr_pend_reg;
  wire sel_am = addr_reg == coef_decode_pkg::alpha_mant_off;
  wire sel_ae = addr_reg == coef_decode_pkg::alpha_exp_off;
  wire sel_bm = addr_reg == coef_decode_pkg::beta_mant_off;
  wire sel_be = addr_reg == coef_decode_pkg::beta_exp_off;
  wire sel_gm = addr_reg == coef_decode_pkg::gamma_mant_off;
  wire sel_ge = addr_reg == coef_decode_pkg::gamma_exp_off;
  wire sel_dm = addr_reg == coef_decode_pkg::delta_mant_off;
  wire sel_de = addr_reg == coef_decode_pkg::delta_exp_off;
  wire sel_st = addr_reg == coef_decode_pkg::status_off;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Capture the address phase; only word offsets in the low byte matter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= addr_take & hwrite;
      rd_pend_reg <= addr_take & ~hwrite;
      addr_reg <= addr_take ? haddr[7:0] : addr_reg;
    end
  end

  // Data phase writes; field widths cap each value to its legal range
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alpha_mant_reg <= coef_decode_pkg::mant_rst[15:0];
      alpha_shift_reg <= coef_decode_pkg::exp_rst;
      alpha_front_reg <= coef_decode_pkg::exp_rst[2:0];
      alpha_back_reg <= coef_decode_pkg::exp_rst[3:0];
      beta_mant_reg <= coef_decode_pkg::mant_rst;
      beta_exp_reg <= coef_decode_pkg::exp_rst[4:0];
      gamma_mant_reg <= coef_decode_pkg::mant_rst;
      gamma_exp_reg <= coef_decode_pkg::exp_rst[4:0];
      delta_mant_reg <= coef_decode_pkg::mant_rst[14:0];
      delta_exp_reg <= coef_decode_pkg::exp_rst[4:0];
    end else if (wr_now) begin
      if (sel_am) begin
        alpha_mant_reg <= hwdata[15:0];
      end else if (sel_ae) begin
        alpha_shift_reg <= hwdata[coef_decode_pkg::shift_lsb +: 6];
        alpha_front_reg <= hwdata[coef_decode_pkg::front_lsb +: 3];
        alpha_back_reg <= hwdata[coef_decode_pkg::back_lsb +: 4];
      end else if (sel_bm) begin
        beta_mant_reg <= hwdata[16:0];
      end else if (sel_be) begin
        beta_exp_reg <= hwdata[4:0];
      end else if (sel_gm) begin
        gamma_mant_reg <= hwdata[16:0];
      end else if (sel_ge) begin
        gamma_exp_reg <= hwdata[4:0];
      end else if (sel_dm) begin
        delta_mant_reg <= hwdata[14:0];
      end else if (sel_de) begin
        delta_exp_reg <= hwdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Shift a mantissa into frac_w fixed point; right shifts drop only
  // bits below the guard range chosen by frac_w
  function automatic logic [coef_w-1:0] scale(input logic [16:0] mant,
                                              input int sh);
    logic [coef_w-1:0] ext;
    ext = coef_w'(mant);
    if (sh >= 0) begin
      scale = ext << sh;
    end else begin
      scale = ext >> (-sh);
    end
  endfunction : scale

  // Total gain clamps at the documented ceiling
  wire [4:0] gain_sum = 5'(alpha_front_reg) + 5'(alpha_back_reg);
  wire gain_clip = gain_sum > coef_decode_pkg::gain_max;
  wire [4:0] gain_eff = gain_clip ? coef_decode_pkg::gain_max : gain_sum;
  // Zero mantissas are raised to the smallest usable value, 1
  wire [16:0] am_eff = (alpha_mant_reg == 16'h0000) ? 17'h00001 :
                       17'(alpha_mant_reg);
  wire [16:0] bm_eff = (beta_mant_reg == 17'h00000) ? 17'h00001 :
                       beta_mant_reg;
  wire [16:0] gm_eff = (gamma_mant_reg == 17'h00000) ? 17'h00001 :
                       gamma_mant_reg;
  wire [16:0] dm_eff = (delta_mant_reg == 15'h0000) ? 17'h00001 :
                       17'(delta_mant_reg);
  // Signed shift counts; a negative count means a right shift
  wire signed [31:0] alpha_sh = frac_w - coef_decode_pkg::alpha_base
                      - int'(alpha_shift_reg) + int'(gain_eff);
  wire signed [31:0] beta_sh = frac_w - coef_decode_pkg::pair_base
                     - int'(beta_exp_reg);
  wire signed [31:0] gamma_sh = frac_w - coef_decode_pkg::pair_base
                      - int'(gamma_exp_reg);
  wire signed [31:0] delta_sh = frac_w - coef_decode_pkg::delta_base
                      - int'(delta_exp_reg);
  wire [coef_w-1:0] alpha_next = scale(am_eff, alpha_sh);
  wire [coef_w-1:0] beta_mag = scale(bm_eff, beta_sh);
  wire [coef_w-1:0] gamma_mag = scale(gm_eff, gamma_sh);
  wire [coef_w-1:0] delta_next = scale(dm_eff, delta_sh);
  wire [coef_w-1:0] beta_next = -beta_mag;
  wire [coef_w-1:0] gamma_next = -gamma_mag;

  // Register the factors so the filter sees glitch-free values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alpha_coef <= '0;
      beta_coef <= '0;
      gamma_coef <= '0;
      delta_coef <= '0;
    end else begin
      alpha_coef <= alpha_next;
      beta_coef <= beta_next;
      gamma_coef <= gamma_next;
      delta_coef <= delta_next;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  wire [31:0] status_word = {27'h0000000,
                             delta_mant_reg == 15'h0000,
                             gamma_mant_reg == 17'h00000,
                             beta_mant_reg == 17'h00000,
                             alpha_mant_reg == 16'h0000,
                             gain_clip};
  wire [31:0] alpha_exp_word = {12'h000, alpha_back_reg, 5'h00,
                                alpha_front_reg, 2'h0, alpha_shift_reg};
  // Mux of flops, steered by the captured address; unmapped reads zero
  wire [31:0] rd_word =
    sel_am ? {16'h0000, alpha_mant_reg} :
    sel_ae ? alpha_exp_word :
    sel_bm ? {15'h0000, beta_mant_reg} :
    sel_be ? {27'h0000000, beta_exp_reg} :
    sel_gm ? {15'h0000, gamma_mant_reg} :
    sel_ge ? {27'h0000000, gamma_exp_reg} :
    sel_dm ? {17'h00000, delta_mant_reg} :
    sel_de ? {27'h0000000, delta_exp_reg} :
    sel_st ? status_word : 32'h00000000;
  assign hrdata = rd_pend_reg ? rd_word : 32'h00000000;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Sampled hresetn in each antecedent except p_write_lands skips the release edge, where
  // the outputs still hold their reset zeros
  property p_alpha_unity;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && alpha_shift_reg == 6'h00 && gain_sum == 5'h00 &&
     alpha_mant_reg != 16'h0000)
    |=> alpha_coef == (coef_w'($past(alpha_mant_reg))
                       << (frac_w - 16));
  endproperty
  a_alpha_unity: assert property (p_alpha_unity)
    else $error("alpha with no shift or gain is wrong");

  property p_alpha_shift_max;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && frac_w <= 64 && alpha_shift_reg == 6'h3f &&
     gain_sum <= 5'h0f)
    |=> alpha_coef == (coef_w'($past(am_eff))
                       >> (79 - frac_w - int'($past(gain_eff))));
  endproperty
  a_alpha_shift_max: assert property (p_alpha_shift_max)
    else $error("alpha at shift 63 scaled wrong");

  property p_alpha_zero;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && alpha_mant_reg == 16'h0000 && alpha_sh >= 0)
    |=> alpha_coef == (coef_w'(1) << $past(alpha_sh));
  endproperty
  a_alpha_zero: assert property (p_alpha_zero)
    else $error("zero alpha mantissa not raised to 1");

  property p_gain_clip;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && alpha_front_reg == 3'h7 && alpha_back_reg == 4'hf &&
     alpha_shift_reg == 6'h00)
    |=> alpha_coef == (coef_w'($past(am_eff)) << (frac_w + 6));
  endproperty
  a_gain_clip: assert property (p_gain_clip)
    else $error("alpha gain not clamped at 22");

  property p_beta_neg;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && beta_exp_reg == 5'h00 && beta_mant_reg != 17'h00000)
    |=> beta_coef == -(coef_w'($past(beta_mant_reg)) << (frac_w - 17));
  endproperty
  a_beta_neg: assert property (p_beta_neg)
    else $error("beta not negated mantissa times 2^-17");

  property p_beta_exp_max;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && beta_exp_reg == 5'h1f && beta_mant_reg != 17'h00000)
    |=> beta_coef == -(coef_w'($past(beta_mant_reg)) << (frac_w - 48));
  endproperty
  a_beta_exp_max: assert property (p_beta_exp_max)
    else $error("beta at exponent 31 wrong");

  property p_gamma_neg;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && gamma_exp_reg == 5'h00 && gamma_mant_reg != 17'h00000)
    |=> gamma_coef == -(coef_w'($past(gamma_mant_reg)) << (frac_w - 17));
  endproperty
  a_gamma_neg: assert property (p_gamma_neg)
    else $error("gamma not negated mantissa times 2^-17");

  property p_delta_pos;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && delta_exp_reg == 5'h00 && delta_mant_reg != 15'h0000)
    |=> delta_coef == (coef_w'($past(delta_mant_reg)) << (frac_w - 15))
        && !delta_coef[coef_w-1];
  endproperty
  a_delta_pos: assert property (p_delta_pos)
    else $error("delta not positive mantissa times 2^-15");

  property p_write_lands;
    @(posedge hclk) disable iff (!hresetn)
    (addr_take && hwrite && haddr[7:0] == coef_decode_pkg::delta_exp_off)
    ##1 hready |=> delta_exp_reg == $past(hwdata[4:0]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("delta exponent write lost");

  c_alpha_gain: cover property (@(posedge hclk)
    gain_sum == coef_decode_pkg::gain_max);
  c_beta_write: cover property (@(posedge hclk) wr_now && sel_bm);
  c_status_read: cover property (@(posedge hclk) rd_pend_reg && sel_st);

endmodule : loop_filter_coefficient_decode

// ---- logic/coef_decode_pkg.sv ----
// Constants for the loop filter coefficient decoder.
package coef_decode_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] alpha_mant_off = 8'h00;
  localparam logic [7:0] alpha_exp_off = 8'h04;
  localparam logic [7:0] beta_mant_off = 8'h08;
  localparam logic [7:0] beta_exp_off = 8'h0c;
  localparam logic [7:0] gamma_mant_off = 8'h10;
  localparam logic [7:0] gamma_exp_off = 8'h14;
  localparam logic [7:0] delta_mant_off = 8'h18;
  localparam logic [7:0] delta_exp_off = 8'h1c;
  localparam logic [7:0] status_off = 8'h20;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int alpha_mant_w = 16;
  localparam int pair_mant_w = 17;
  localparam int delta_mant_w = 15;
  localparam int shift_w = 6;
  localparam int front_w = 3;
  localparam int back_w = 4;
  localparam int exp_w = 5;
  localparam int shift_lsb = 0;
  localparam int front_lsb = 8;
  localparam int back_lsb = 16;

  // Status bit positions
  localparam int st_gain_clip = 0;
  localparam int st_alpha_zero = 1;
  localparam int st_beta_zero = 2;
  localparam int st_gamma_zero = 3;
  localparam int st_delta_zero = 4;

  // ----------------------------------------------------------------
  // Reset values and scaling constants
  // ----------------------------------------------------------------
  localparam logic [16:0] mant_rst = 17'h00001;
  localparam logic [5:0] exp_rst = 6'h00;
  localparam int alpha_base = 16;
  localparam int pair_base = 17;
  localparam int delta_base = 15;
  localparam logic [4:0] gain_max = 5'h16;

  // AHB transfer type
  localparam logic [1:0] htrans_nonseq = 2'h2;

endpackage : coef_decode_pkg

// ---- dv/loop_filter_coefficient_decode_tb_top.sv ----
// Self-checking testbench for the loop filter coefficient decoder.
`timescale 1ns/10ps

module loop_filter_coefficient_decode_tb_top;

  // ----------------------------------------------------------------
  // Bench signals, all inputs valued at time zero
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic signed [71:0] alpha_coef;
  logic signed [71:0] beta_coef;
  logic signed [71:0] gamma_coef;
  logic signed [71:0] delta_coef;
  int n_errors = 0;
  int checked = 0;

  // Field masks per register, in offset order
  localparam logic [31:0] masks [8] = '{32'h0000ffff, 32'h000f073f,
    32'h0001ffff, 32'h0000001f, 32'h0001ffff, 32'h0000001f,
    32'h00007fff, 32'h0000001f};

  // Field sets: worked example, maxima, smallest, zero mantissas with junk
  logic [31:0] cases [4][8] = '{
    '{32'h0000d0a8, 32'h00000006, 32'h0001250b, 32'h0000000d,
      32'h00013abb, 32'h0000000d, 32'h0000420a, 32'h00000008},
    '{32'h0000ffff, 32'h000f0700, 32'h0001ffff, 32'h0000001f,
      32'h0001ffff, 32'h00000000, 32'h00007fff, 32'h0000001f},
    '{32'h00000001, 32'h0002033f, 32'h00000001, 32'h00000000,
      32'h00000002, 32'h0000001f, 32'h00000001, 32'h00000000},
    '{32'hffff0000, 32'hfffff7e0, 32'hfffe0000, 32'hffffffe3,
      32'hfffe0000, 32'hffffffff, 32'hffff8000, 32'hffffffe0}};
  logic [31:0] status_exp [4] = '{32'h0, 32'h0, 32'h0, 32'h0000001e};

  // One slave only, so its ready is the bus ready
  assign hready = hreadyout;

  // 100 MHz clock
  always #5 hclk = ~hclk;

  loop_filter_coefficient_decode u_loop_filter_coefficient_decode (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .alpha_coef(alpha_coef),
    .beta_coef(beta_coef),
    .gamma_coef(gamma_coef),
    .delta_coef(delta_coef)
  );

  // ----------------------------------------------------------------
  // Compare tasks and reference scaling
  // ----------------------------------------------------------------
  task automatic cmp_word(input string what, input logic [31:0] exp_v,
                          input logic [31:0] got);
    checked++;
    if (got !== exp_v) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp_v, got);
    end
  endtask : cmp_word

  task automatic cmp_coef(input string what, input logic [71:0] exp_v,
                          input logic [71:0] got);
    checked++;
    if (got !== exp_v) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp_v, got);
    end
  endtask : cmp_coef

  // Mantissa zero decodes as one; a negative shift truncates low bits
  function automatic logic [71:0] scale(input logic [31:0] m, input int k,
                                        input bit neg);
    logic [71:0] v;
    v = {40'h0, (m == 32'h0) ? 32'h1 : m};
    v = (k >= 0) ? (v << k) : (v >> (-k));
    return neg ? -v : v;
  endfunction : scale

  // ----------------------------------------------------------------
  // Bus tasks: called right after a rising edge, end on one
  // ----------------------------------------------------------------
  task automatic bus_xfer(input logic wr, input logic [7:0] off,
                          input logic [31:0] wdata, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= coef_decode_pkg::htrans_nonseq;
    haddr <= {24'h0, off};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    cmp_word("hresp", 32'h0, {31'h0, hresp});
  endtask : bus_xfer

  task automatic bus_write(input logic [7:0] off, input logic [31:0] d);
    logic [31:0] unused;
    bus_xfer(1'b1, off, d, unused);
  endtask : bus_write

  task automatic read_check(input logic [7:0] off, input logic [31:0] exp_v);
    logic [31:0] rd;
    bus_xfer(1'b0, off, 32'h0, rd);
    cmp_word($sformatf("read %h", off), exp_v, rd);
  endtask : read_check

  // Coefficients follow the field registers one cycle after the store
  task automatic check_coefs(input logic [31:0] f [8]);
    int g;
    g = int'(f[1][10:8]) + int'(f[1][19:16]);
    g = (g > 22) ? 22 : g;
    repeat (2) @(posedge hclk);
    cmp_coef("alpha", scale(f[0], 32 - int'(f[1][5:0]) + g, 0),
             alpha_coef);
    cmp_coef("beta", scale(f[2], 31 - int'(f[3]), 1), beta_coef);
    cmp_coef("gamma", scale(f[4], 31 - int'(f[5]), 1), gamma_coef);
    cmp_coef("delta", scale(f[6], 33 - int'(f[7]), 0), delta_coef);
  endtask : check_coefs

  // Write each field, read it back at once, then check the outputs
  task automatic run_case(input int c);
    logic [31:0] f [8];
    for (int i = 0; i < 8; i++) begin
      f[i] = cases[c][i] & masks[i];
      bus_write(8'(i * 4), cases[c][i]);
      read_check(8'(i * 4), f[i]);
    end
    check_coefs(f);
    read_check(coef_decode_pkg::status_off, status_exp[c]);
    $display("Test field set %0d done, errors %0d", c, n_errors);
  endtask : run_case

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] f [8];
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset fields: mantissas one, exponents zero
    for (int i = 0; i < 8; i++) begin
      f[i] = (i % 2 == 0) ? 32'h1 : 32'h0;
      read_check(8'(i * 4), f[i]);
    end
    check_coefs(f);
    $display("Test reset values done, errors %0d", n_errors);
    for (int c = 0; c < 4; c++) begin
      run_case(c);
    end
    // Unmapped places: writes ignored, reads zero, fields untouched
    bus_write(8'h24, 32'hffffffff);
    read_check(8'h24, 32'h0);
    bus_write(8'hfc, 32'hffffffff);
    read_check(8'hfc, 32'h0);
    for (int i = 0; i < 8; i++) begin
      f[i] = cases[3][i] & masks[i];
    end
    check_coefs(f);
    $display("Test unmapped access done, errors %0d", n_errors);
    complete_run();
  end

  // Watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    $display("Error watchdog expected finish seen hang");
    complete_run();
  end

endmodule : loop_filter_coefficient_decode_tb_top
